// [hdl/cr_wd_defs.svh]
`ifndef CR_WD_DEFS_SVH
`define CR_WD_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ADDR_GLITCH          8'h66
`define ADDR_PHASE           8'h68
`define ADDR_WD_STATUS       8'h6E
`define ADDR_MASK            8'h6F
`define ADDR_HOLD            8'h70
`define ADDR_RELEASE         8'h71
`define ADDR_UPPER_HI        8'h72
`define ADDR_UPPER_LO        8'h73
`define ADDR_LOWER_EN        8'h74
`define ADDR_SYS_STATUS      8'h75

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_GLITCH           8'h0F
`define RST_PHASE            8'h60
`define RST_MASK             8'h00
`define RST_HOLD             8'h00
`define RST_RELEASE          8'h10
`define RST_UPPER_HI         8'h00
`define RST_UPPER_LO         8'h20
`define RST_LOWER_EN         8'h90

// ----------------------------------------------------------------
// field positions and codes
// ----------------------------------------------------------------
`define GLITCH_BYPASS_BIT    7
`define WATCHDOG_ENABLE_BIT  0
`define LOWER_LSB            4
`define FINE_MAX             4'h9
`define COARSE_MAX           4'hC
`define SE_FINE              4'h0
`define SE_COARSE            4'h6
`define PDM_NORMAL           2'h3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define REF_PERIOD_NS        10
`define GLITCH_MIN_NS        20
`define GLITCH_EXTRA_CYC     ((`GLITCH_MIN_NS + `REF_PERIOD_NS - 1) / `REF_PERIOD_NS)
`define RELEASE_UNIT_MS      10
`define RELEASE_UNIT_CYC     (`RELEASE_UNIT_MS * 1000000 / `REF_PERIOD_NS)
`define PERM_LOW_MS          10
`define PERM_LOW_CYC         (`PERM_LOW_MS * 1000000 / `REF_PERIOD_NS)
`define REF_QUARTER_DIV      4

`endif

// [hdl/cr_wd_pkg.sv]
package cr_wd_pkg;

   typedef enum logic [2:0] {
      WD_OFF = 3'b001,
      WD_RUN = 3'b010,
      WD_ERR = 3'b100
   } wd_state_e;

   typedef struct packed {
      logic [1:0] sample_rate_code;
      logic       switching_state;
      logic [1:0] power_stage_fault_code;
      logic       clock_ratio_ok;
      logic       pll_unlock_flag;
   } sys_in_s;

   typedef struct packed {
      logic [3:0] phase_coarse_step;
      logic [3:0] phase_fine_step;
   } phase_s;

endpackage

// [hdl/clock_ratio_watchdog_status.sv]
// Operation
// RULE1: filter bus glitches narrower than width plus 20ns
// RULE2: fine phase code 0..9, 1.66 degree steps
// RULE3: coarse phase code 0..12, 15 degree steps
// RULE4: single-ended mode forces fine 0, coarse 6
// RULE5: read-only watchdog status, four error bits
// RULE6: low mask nibble validates status for pwm-off
// RULE7: high mask nibble validates status for gating
// RULE8: hold enables freeze status on first change
// RULE9: watchdog error clears after release count times 10ms
// RULE10: ratio above 16-bit upper limit flags error
// RULE11: four-bit lower limit; watchdog runs when enabled
// RULE12: flag gating output held permanently low
// RULE13: report pll unlock and clock ratio ok
// RULE14: two-bit power stage fault code, 11 normal
// RULE15: report switching state and sample rate code
// RULE16: reserved addresses read zero, have no function
// RULE17: status writes ignored, reads return status
// RULE18: ratio outside lower/upper band flags bit-clock error
`include "cr_wd_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module clock_ratio_watchdog_status
   import cr_wd_pkg::*;
#(
   parameter int unsigned P_RELEASE_UNIT_CYC = `RELEASE_UNIT_CYC,
   parameter int unsigned P_PERM_LOW_CYC     = `PERM_LOW_CYC
) (
   input  wire logic       i_ref_clk,
   input  wire logic       i_reset_n,
   input  wire logic       i_reg_wr,
   input  wire logic       i_reg_rd,
   input  wire logic [7:0] i_reg_addr,
   input  wire logic [7:0] i_reg_wdata,
   output logic      [7:0] o_reg_rdata,
   input  wire logic [1:0] i_bus_line,
   output logic      [1:0] o_bus_line_filt,
   input  wire logic       i_single_ended,
   output phase_s          o_phase,
   input  wire logic       i_bck,
   input  wire logic       i_wordclk_ratio_error,
   input  wire logic       i_modulation_index_error,
   input  wire sys_in_s    i_sys,
   output logic            o_pwm_off,
   output logic            o_pwm_gate_n
);

   // ----------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------
   logic [7:0]  glitch_r;
   logic [7:0]  phase_r;
   logic [7:0]  mask_r;
   logic [7:0]  hold_r;
   logic [7:0]  release_r;
   logic [15:0] upper_r;
   logic [7:0]  lower_en_r;
   logic [3:0]  wd_st;
   logic [7:0]  sys_st;
   logic [7:0]  rdata_r;

   function automatic logic [7:0] reg_read(input logic [7:0] a);
      case (a)
         `ADDR_GLITCH:     reg_read = glitch_r;
         `ADDR_PHASE:      reg_read = phase_r;
         `ADDR_WD_STATUS:  reg_read = {4'h0, wd_st};
         `ADDR_MASK:       reg_read = mask_r;
         `ADDR_HOLD:       reg_read = hold_r;
         `ADDR_RELEASE:    reg_read = release_r;
         `ADDR_UPPER_HI:   reg_read = upper_r[15:8];
         `ADDR_UPPER_LO:   reg_read = upper_r[7:0];
         `ADDR_LOWER_EN:   reg_read = lower_en_r;
         `ADDR_SYS_STATUS: reg_read = sys_st;
         default:          reg_read = 8'h00; // RULE16
      endcase
   endfunction

   // status offsets fall to default: writes there change nothing
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         glitch_r   <= `RST_GLITCH;
         phase_r    <= `RST_PHASE;
         mask_r     <= `RST_MASK;
         hold_r     <= `RST_HOLD;
         release_r  <= `RST_RELEASE;
         upper_r    <= {`RST_UPPER_HI, `RST_UPPER_LO};
         lower_en_r <= `RST_LOWER_EN;
      end else if (i_reg_wr) begin
         case (i_reg_addr) // RULE17
            `ADDR_GLITCH:   glitch_r <= i_reg_wdata;
            `ADDR_PHASE:    phase_r <= i_reg_wdata;
            `ADDR_MASK:     mask_r <= i_reg_wdata;
            `ADDR_HOLD:     hold_r <= i_reg_wdata & 8'hEE;
            `ADDR_RELEASE:  release_r <= i_reg_wdata;
            `ADDR_UPPER_HI: upper_r[15:8] <= i_reg_wdata;
            `ADDR_UPPER_LO: upper_r[7:0] <= i_reg_wdata;
            `ADDR_LOWER_EN: lower_en_r <= i_reg_wdata & 8'hF1;
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rdata_r <= 8'h00;
      end else if (i_reg_rd) begin
         rdata_r <= reg_read(i_reg_addr); // RULE17
      end
   end
   assign o_reg_rdata = rdata_r;

   // ----------------------------------------------------------------
   // control bus glitch filter
   // ----------------------------------------------------------------
   logic [7:0] glitch_need;
   logic       bypass;
   logic [7:0] gcnt_r [2];
   logic [1:0] filt_r;

   assign bypass      = glitch_r[`GLITCH_BYPASS_BIT];
   assign glitch_need = {1'b0, glitch_r[6:0]} + 8'(`GLITCH_EXTRA_CYC);

   generate
      for (genvar g = 0; g < 2; g++) begin : g_filt
         // a level must persist glitch_need cycles before it is passed on
         always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
               filt_r[g] <= 1'b1;
               gcnt_r[g] <= 8'h00;
            end else if (bypass || i_bus_line[g] == filt_r[g]) begin
               filt_r[g] <= i_bus_line[g]; // RULE1
               gcnt_r[g] <= 8'h00;
            end else if (gcnt_r[g] + 8'h01 >= glitch_need) begin
               filt_r[g] <= i_bus_line[g]; // RULE1
               gcnt_r[g] <= 8'h00;
            end else begin
               gcnt_r[g] <= gcnt_r[g] + 8'h01;
            end
         end

         chk_glitch_width : assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
            (!bypass && $changed(i_bus_line[g])) |=> !$changed(filt_r[g])) // RULE1
            else $error("bus line passed without filter delay");
      end
   endgenerate
   assign o_bus_line_filt = filt_r;

   chk_glitch_bypass : assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      (bypass && $past(bypass)) |-> filt_r == $past(i_bus_line)) // RULE1
      else $error("bypass does not pass bus line through");

   // ----------------------------------------------------------------
   // pwm phase offset
   // ----------------------------------------------------------------
   phase_s phase_out_r;

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         phase_out_r <= {`SE_COARSE, `SE_FINE};
      end else if (i_single_ended) begin
         phase_out_r <= {`SE_COARSE, `SE_FINE}; // RULE4
      end else begin
         // out-of-range codes clamp rather than wrap to a small offset
         phase_out_r.phase_fine_step <= (phase_r[3:0] > `FINE_MAX) ?
                                        `FINE_MAX : phase_r[3:0]; // RULE2
         phase_out_r.phase_coarse_step <= (phase_r[7:4] > `COARSE_MAX) ?
                                          `COARSE_MAX : phase_r[7:4]; // RULE3
      end
   end
   assign o_phase = phase_out_r;

   chk_single_ended : assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      $past(i_single_ended) |-> (o_phase.phase_fine_step == `SE_FINE &&
                                 o_phase.phase_coarse_step == `SE_COARSE)) // RULE4
      else $error("single-ended phase not forced");
   chk_phase_range : assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      !$past(i_single_ended) |-> (o_phase.phase_fine_step <= `FINE_MAX &&
                                  o_phase.phase_coarse_step <= `COARSE_MAX)) // RULE2 RULE3
      else $error("phase code out of range");

   // ----------------------------------------------------------------
   // bit clock ratio measurement
   // ----------------------------------------------------------------
   logic        watchdog_enable;
   logic [3:0]  ratio_lower_limit;
   logic [1:0]  qdiv_r;
   logic        qtick;
   logic        bck_d_r;
   logic        bck_edge;
   logic [15:0] meas_r;
   logic        bk_err_r;

   assign watchdog_enable               = lower_en_r[`WATCHDOG_ENABLE_BIT];
   assign ratio_lower_limit = lower_en_r[`LOWER_LSB +: 4];
   assign qtick             = (qdiv_r == 2'(`REF_QUARTER_DIV - 1));
   assign bck_edge          = i_bck & ~bck_d_r;

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         qdiv_r  <= 2'h0;
         bck_d_r <= 1'b0;
      end else begin
         qdiv_r  <= qdiv_r + 2'h1;
         bck_d_r <= i_bck;
      end
   end

   // counts quarter-rate reference ticks per bit clock period
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         meas_r   <= 16'h0000;
         bk_err_r <= 1'b0;
      end else if (!watchdog_enable) begin
         meas_r   <= 16'h0000; // RULE11
         bk_err_r <= 1'b0;
      end else if (bck_edge) begin
         meas_r   <= 16'h0000;
         bk_err_r <= (meas_r > upper_r) ||
                     (meas_r < {12'h000, ratio_lower_limit}); // RULE10 RULE18
      end else begin
         if (qtick && meas_r != 16'hFFFF) begin
            meas_r <= meas_r + 16'h0001;
         end
         // a stopped bit clock must not hide behind a missing edge
         if (meas_r > upper_r) begin
            bk_err_r <= 1'b1; // RULE10
         end
      end
   end

   chk_upper_limit : assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      (watchdog_enable && meas_r > upper_r && $stable(lower_en_r)) |=> bk_err_r) // RULE10
      else $error("ratio above upper limit not flagged");
   chk_lower_limit : assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      (watchdog_enable && bck_edge && meas_r < {12'h000, ratio_lower_limit} && $stable(lower_en_r))
      |=> bk_err_r) // RULE18
      else $error("ratio below lower limit not flagged");

   // ----------------------------------------------------------------
   // watchdog error and release
   // ----------------------------------------------------------------
   wd_state_e   wd_state_r;
   logic [23:0] rel_tick_r;
   logic [7:0]  rel_cnt_r;

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wd_state_r <= WD_OFF;
         rel_tick_r <= 24'h000000;
         rel_cnt_r  <= 8'h00;
      end else begin
         case (wd_state_r)
            WD_OFF: begin
               if (watchdog_enable) begin
                  wd_state_r <= WD_RUN; // RULE11
               end
            end
            WD_RUN: begin
               rel_tick_r <= 24'h000000;
               rel_cnt_r  <= 8'h00;
               if (!watchdog_enable) begin
                  wd_state_r <= WD_OFF;
               end else if (bk_err_r) begin
                  wd_state_r <= WD_ERR;
               end
            end
            WD_ERR: begin
               if (!watchdog_enable) begin
                  wd_state_r <= WD_OFF;
               end else if (bk_err_r) begin
                  rel_tick_r <= 24'h000000; // RULE9
                  rel_cnt_r  <= 8'h00;
               end else if (rel_cnt_r >= release_r) begin
                  wd_state_r <= WD_RUN; // RULE9
               end else if (rel_tick_r == 24'(P_RELEASE_UNIT_CYC - 1)) begin
                  rel_tick_r <= 24'h000000;
                  rel_cnt_r  <= rel_cnt_r + 8'h01;
               end else begin
                  rel_tick_r <= rel_tick_r + 24'h000001;
               end
            end
            default: wd_state_r <= WD_OFF;
         endcase
      end
   end

   chk_release_hold : assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      (wd_state_r == WD_ERR && watchdog_enable && rel_cnt_r < release_r) |=> wd_state_r == WD_ERR) // RULE9
      else $error("watchdog error released early");
   chk_release_done : assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      (wd_state_r == WD_ERR && watchdog_enable && !bk_err_r && rel_cnt_r >= release_r)
      |=> wd_state_r == WD_RUN) // RULE9
      else $error("watchdog error not released");

   // ----------------------------------------------------------------
   // status holding
   // ----------------------------------------------------------------
   localparam int HOLD_POS [6] = '{1, 2, 3, 5, 6, 7};
   logic [5:0] live6;
   logic [5:0] st6_r;
   logic [5:0] frz_r;
   logic [5:0] hen;

   // order: pll unlock, clock ratio, modulation, watchdog, bit clk, word clk
   assign live6 = {i_wordclk_ratio_error, bk_err_r, (wd_state_r == WD_ERR),
                   i_modulation_index_error, i_sys.clock_ratio_ok,
                   i_sys.pll_unlock_flag};

   generate
      for (genvar h = 0; h < 6; h++) begin : g_hold
         assign hen[h] = hold_r[HOLD_POS[h]];
         always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
               st6_r[h] <= 1'b0;
               frz_r[h] <= 1'b0;
            end else if (!hen[h]) begin
               st6_r[h] <= live6[h]; // RULE8
               frz_r[h] <= 1'b0;
            end else if (!frz_r[h]) begin
               st6_r[h] <= live6[h];
               frz_r[h] <= (live6[h] != st6_r[h]); // RULE8
            end
         end
      end
   endgenerate

   chk_hold_freeze : assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      ((frz_r & hen) != 6'h00) |=> ((st6_r ^ $past(st6_r)) & $past(frz_r & hen)) == 6'h00) // RULE8
      else $error("held status bit changed");

   // ----------------------------------------------------------------
   // status registers and gating
   // ----------------------------------------------------------------
   logic        gate_n_r;
   logic        pwm_off_r;
   logic        perm_r;
   logic [23:0] low_cnt_r;

   assign wd_st  = {st6_r[2], st6_r[5], st6_r[4], st6_r[3]}; // RULE5
   assign sys_st = {i_sys.sample_rate_code, i_sys.switching_state,
                    i_sys.power_stage_fault_code, st6_r[1], st6_r[0],
                    perm_r}; // RULE13 RULE14 RULE15

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pwm_off_r <= 1'b0;
         gate_n_r  <= 1'b1;
      end else begin
         pwm_off_r <= |(wd_st & mask_r[3:0]); // RULE6
         gate_n_r  <= ~|(wd_st & mask_r[7:4]); // RULE7
      end
   end
   assign o_pwm_off    = pwm_off_r;
   assign o_pwm_gate_n = gate_n_r;

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         low_cnt_r <= 24'h000000;
         perm_r    <= 1'b0;
      end else if (gate_n_r) begin
         low_cnt_r <= 24'h000000;
         perm_r    <= 1'b0;
      end else if (low_cnt_r == 24'(P_PERM_LOW_CYC - 1)) begin
         perm_r <= 1'b1; // RULE12
      end else begin
         low_cnt_r <= low_cnt_r + 24'h000001;
      end
   end

   chk_pwm_off_mask : assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      ##1 o_pwm_off == |($past(wd_st) & $past(mask_r[3:0]))) // RULE6
      else $error("pwm-off does not follow masked status");
   chk_gate_mask : assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      ((wd_st & mask_r[7:4]) != 4'h0) |=> !o_pwm_gate_n ##1 1'b1) // RULE7
      else $error("gating not asserted on valid status");
   chk_perm_low : assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      perm_r |-> !$past(gate_n_r)) // RULE12
      else $error("permanent low flag with gate high");
   chk_ro_write : assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      (i_reg_wr && i_reg_addr == `ADDR_WD_STATUS) |=> $stable(mask_r) && $stable(hold_r)) // RULE17
      else $error("status write altered a register");

endmodule

`default_nettype wire

// [dv/bck_source.sv]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// audio bit clock source, period in core clocks
// ----------------------------------------------------------------
module bck_source (
   input  wire logic i_clk,
   input  wire logic i_run,
   input  var  int   i_period,
   output var  logic o_bck
);
   int cnt;

   initial begin
      cnt   = 0;
      o_bck = 1'b0;
   end

   // parked low between runs, as a stopped source would be
   always @(negedge i_clk) begin
      if (!i_run) begin
         cnt   <= 0;
         o_bck <= 1'b0;
      end else begin
         cnt   <= (cnt >= i_period - 1) ? 0 : cnt + 1;
         o_bck <= (cnt < i_period / 2);
      end
   end
endmodule

`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/1ps
`default_nettype none

module tb;
   import cr_wd_pkg::*;

   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic       clk;
   logic       rst_n;
   logic       wr;
   logic       rd;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic [1:0] bus;
   logic [1:0] filt;
   logic       se;
   phase_s     phase;
   logic       bck;
   logic       bck_run;
   int         bck_period;
   logic       wck_err;
   logic       mod_err;
   sys_in_s    sys;
   logic       pwm_off;
   logic       gate_n;
   int         num_errors;
   int         comparisons;
   int         cycles;
   logic [7:0] exp_tab [8];
   logic [7:0] adr_tab [8];

   // ----------------------------------------------------------------
   // clock, design and source
   // ----------------------------------------------------------------
   always #5 clk = ~clk;

   clock_ratio_watchdog_status #(
      .P_RELEASE_UNIT_CYC (20),
      .P_PERM_LOW_CYC     (16)
   ) dut_u (
      .i_ref_clk                (clk),
      .i_reset_n                (rst_n),
      .i_reg_wr                 (wr),
      .i_reg_rd                 (rd),
      .i_reg_addr               (addr),
      .i_reg_wdata              (wdata),
      .o_reg_rdata              (rdata),
      .i_bus_line               (bus),
      .o_bus_line_filt          (filt),
      .i_single_ended           (se),
      .o_phase                  (phase),
      .i_bck                    (bck),
      .i_wordclk_ratio_error    (wck_err),
      .i_modulation_index_error (mod_err),
      .i_sys                    (sys),
      .o_pwm_off                (pwm_off),
      .o_pwm_gate_n             (gate_n)
   );

   bck_source src_u (
      .i_clk    (clk),
      .i_run    (bck_run),
      .i_period (bck_period),
      .o_bck    (bck)
   );

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      wr    = 1'b1;
      addr  = a;
      wdata = d;
      @(negedge clk);
      wr    = 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk);
      rd   = 1'b1;
      addr = a;
      @(negedge clk);
      rd   = 1'b0;
      @(negedge clk);
      chk($sformatf("reg %h", a), exp, rdata);
   endtask

   // low pulse of n cycles on line 0, reports whether it got through
   task automatic glitch(input int n, input logic exp_seen);
      logic seen;
      int   i;
      seen = 1'b0;
      for (i = 0; i < n + 24; i++) begin
         @(negedge clk);
         bus[0] = (i < n) ? 1'b0 : 1'b1;
         if (filt[0] === 1'b0) seen = 1'b1;
      end
      chk("filtered line", {7'h00, exp_seen}, {7'h00, seen});
      chk("idle line", 8'h01, {7'h00, filt[1]});
   endtask

   task automatic outs(input logic off, input logic gn);
      chk("pwm off", {7'h00, off}, {7'h00, pwm_off});
      chk("gate", {7'h00, gn}, {7'h00, gate_n});
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // generous ceiling; the sequence needs roughly 2000 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles >= 30000) begin
         num_errors++;
         tally_and_finish();
      end
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0; rst_n = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 8'h00;
      bus = 2'h3; se = 1'b0; bck_run = 1'b0; bck_period = 80; wck_err = 1'b0;
      mod_err = 1'b0; sys = 7'h3E; num_errors = 0; comparisons = 0; cycles = 0;
      adr_tab = '{8'h66, 8'h68, 8'h6F, 8'h70, 8'h71, 8'h72, 8'h73, 8'h74};
      exp_tab = '{8'h0F, 8'h60, 8'h00, 8'h00, 8'h10, 8'h00, 8'h20, 8'h90};
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      // reset values
      for (int i = 0; i < 8; i++) reg_rd(adr_tab[i], exp_tab[i]);
      chk("phase", 8'h60, phase);
      reg_rd(8'h6E, 8'h00);
      reg_rd(8'h75, 8'h7C);
      // reserved places and read-only status
      foreach (adr_tab[i]) reg_wr(adr_tab[i] ^ 8'h0F, 8'hFF);
      reg_wr(8'h6E, 8'hFF);
      reg_wr(8'h75, 8'hFF);
      reg_rd(8'h62, 8'h00);
      reg_rd(8'h67, 8'h00);
      reg_rd(8'h6D, 8'h00);
      reg_rd(8'h6E, 8'h00);
      reg_rd(8'h75, 8'h7C);
      reg_rd(8'h66, 8'h0F);
      reg_wr(8'h70, 8'hFF);
      reg_rd(8'h70, 8'hEE);
      reg_wr(8'h74, 8'hFF);
      reg_rd(8'h74, 8'hF1);
      reg_wr(8'h70, 8'h00);
      reg_wr(8'h74, 8'h90);
      // glitch filter: default width needs 17 cycles, bypass passes all
      glitch(16, 1'b0);
      glitch(17, 1'b1);
      reg_wr(8'h66, 8'h80);
      glitch(1, 1'b1);
      reg_wr(8'h66, 8'h00);
      glitch(1, 1'b0);
      glitch(2, 1'b1);
      // phase codes, out-of-range clamps, single-ended override
      reg_wr(8'h68, 8'hC9);
      wait_cyc(2);
      chk("phase", 8'hC9, phase);
      reg_wr(8'h68, 8'h35);
      wait_cyc(2);
      chk("phase", 8'h35, phase);
      reg_wr(8'h68, 8'hFF);
      wait_cyc(2);
      chk("phase", 8'hC9, phase);
      se = 1'b1;
      wait_cyc(2);
      chk("phase", 8'h60, phase);
      se = 1'b0;
      // every power-stage code and rate codes 0 to 2 pass through
      for (int r = 0; r < 3; r++) begin
         for (int p = 0; p < 4; p++) begin
            sys = {r[1:0], 1'b1, p[1:0], 1'b0, 1'b0};
            wait_cyc(3);
            reg_rd(8'h75, {r[1:0], 1'b1, p[1:0], 3'b000});
         end
      end
      sys = 7'h3E;
      // hold on first change of the pll flag
      reg_wr(8'h70, 8'h02);
      sys.pll_unlock_flag = 1'b1;
      wait_cyc(3);
      sys.pll_unlock_flag = 1'b0;
      wait_cyc(3);
      reg_rd(8'h75, 8'h7E);
      reg_wr(8'h70, 8'h00);
      wait_cyc(3);
      reg_rd(8'h75, 8'h7C);
      // watchdog: in band, too slow, recovery, too fast
      reg_wr(8'h71, 8'h01);
      reg_wr(8'h6F, 8'h33);
      reg_wr(8'h74, 8'h91);
      bck_run = 1'b1;
      wait_cyc(400);
      reg_rd(8'h6E, 8'h00);
      outs(1'b0, 1'b1);
      bck_period = 200;
      wait_cyc(600);
      reg_rd(8'h6E, 8'h03);
      outs(1'b1, 1'b0);
      reg_rd(8'h75, 8'h7D);
      bck_period = 80;
      wait_cyc(400);
      reg_rd(8'h6E, 8'h00);
      outs(1'b0, 1'b1);
      reg_rd(8'h75, 8'h7C);
      bck_period = 16;
      wait_cyc(200);
      reg_rd(8'h6E, 8'h03);
      reg_wr(8'h74, 8'h90);
      wait_cyc(10);
      reg_rd(8'h6E, 8'h00);
      bck_run = 1'b0;
      // live error inputs, one mask nibble at a time
      mod_err = 1'b1;
      wck_err = 1'b1;
      reg_wr(8'h6F, 8'h80);
      wait_cyc(4);
      reg_rd(8'h6E, 8'h0C);
      outs(1'b0, 1'b0);
      reg_wr(8'h6F, 8'h04);
      wait_cyc(4);
      outs(1'b1, 1'b1);
      mod_err = 1'b0;
      wck_err = 1'b0;
      wait_cyc(4);
      outs(1'b0, 1'b1);
      tally_and_finish();
   end
endmodule

`default_nettype wire
